// >>> inc/sbw_pkg.sv
// package: constants and types for the staged boot/runtime watchdog
package sbw_pkg;
  // ****************************************************************
  // tick and timing
  // ****************************************************************
  localparam int unsigned CLK_HZ      = 10_000_000;
  localparam int unsigned TICK_SEC    = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_SEC;
  localparam logic [15:0] CNT_RESET   = 16'h0000;

  // ****************************************************************
  // selector encodings
  // ****************************************************************
  // boot timeout: 0 disabled, 1..6 = 30s,1m,2m,5m,10m,30m
  localparam logic [2:0] BOOT_OFF = 3'h0;
  // start delay: 0 disabled, 1..7 = 10s,30s,1m,2m,5m,10m,30m
  localparam logic [2:0] DLY_OFF  = 3'h0;
  // stage timeout: 0..9 = 1s,2s,5s,10s,30s,1m,2m,5m,10m,30m

  typedef enum logic [1:0] {
    SBW_MODE_OFF    = 2'h0,
    SBW_MODE_ONCE   = 2'h1,
    SBW_MODE_SINGLE = 2'h2,
    SBW_MODE_REPEAT = 2'h3
  } sbw_mode_t;

  typedef enum logic [1:0] {
    SBW_EV_OFF   = 2'h0,
    SBW_EV_ACPI  = 2'h1,
    SBW_EV_RESET = 2'h2,
    SBW_EV_PWR   = 2'h3
  } sbw_event_t;

  // gray along idle -> delay -> stage1 -> stage2 -> stage3
  typedef enum logic [2:0] {
    SBW_IDLE  = 3'h0,
    SBW_DELAY = 3'h1,
    SBW_ST1   = 3'h3,
    SBW_ST2   = 3'h2,
    SBW_ST3   = 3'h6,
    SBW_DONE  = 3'h7
  } sbw_state_t;
endpackage

// >>> logic/sbw_tick.sv
// one-second tick generator from the system clock
module sbw_tick #(
  parameter int unsigned TICK_CYCLES = sbw_pkg::TICK_CYCLES
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  output logic      tick
);
  // ****************************************************************
  // elaboration check
  // ****************************************************************
  if (TICK_CYCLES < 2 || TICK_CYCLES > 32'h0100_0000) begin : g_chk
    $error("tick cycles out of range");
  end

  typedef struct packed {
    logic [23:0] cnt;
    logic        tick;
  } sbw_tick_t;

  sbw_tick_t st_ff;
  sbw_tick_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    if (st_ff.cnt == 24'(TICK_CYCLES - 1)) begin
      nxt_st.cnt  = 24'h00_0000;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + 24'h00_0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tick = st_ff.tick;

  a_tick_period: assert property (@(posedge ref_clk) disable iff (rst)
    tick |=> !tick) else $error("tick not a single pulse");
endmodule

// >>> logic/sbw_watchdog.sv
// staged boot-phase and runtime watchdog
module sbw_watchdog #(
  parameter int unsigned TICK_CYCLES = sbw_pkg::TICK_CYCLES
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic [2:0]       boot_timeout_sel,
  input  wire logic             boot_pause_en,
  input  wire logic             post_active,
  input  wire logic             user_wait,
  input  wire logic             os_arm,
  input  wire sbw_pkg::sbw_mode_t  rt_mode,
  input  wire logic [2:0]       rt_delay_sel,
  input  wire sbw_pkg::sbw_event_t ev1_sel,
  input  wire sbw_pkg::sbw_event_t ev2_sel,
  input  wire sbw_pkg::sbw_event_t ev3_sel,
  input  wire logic [3:0]       tmo1_sel,
  input  wire logic [3:0]       tmo2_sel,
  input  wire logic [3:0]       tmo3_sel,
  input  wire logic             acpi_restart_sel,
  input  wire logic             sw_trigger,
  output logic                  sys_reset,
  output logic                  pwr_button,
  output logic                  overtemp_notify,
  output logic                  acpi_fatal,
  output logic                  rt_active,
  output logic [2:0]            rt_stage
);
  // ****************************************************************
  // decode functions (seconds)
  // ****************************************************************
  function automatic logic [15:0] boot_secs(input logic [2:0] s);
    case (s)
      3'h1:    boot_secs = 16'h001E;
      3'h2:    boot_secs = 16'h003C;
      3'h3:    boot_secs = 16'h0078;
      3'h4:    boot_secs = 16'h012C;
      3'h5:    boot_secs = 16'h0258;
      3'h6:    boot_secs = 16'h0708;
      default: boot_secs = 16'h0000;
    endcase
  endfunction

  function automatic logic [15:0] dly_secs(input logic [2:0] s);
    case (s)
      3'h1:    dly_secs = 16'h000A;
      3'h2:    dly_secs = 16'h001E;
      default: dly_secs = boot_secs(s - 3'h1);
    endcase
  endfunction

  function automatic logic [15:0] tmo_secs(input logic [3:0] s);
    case (s)
      4'h0:    tmo_secs = 16'h0001;
      4'h1:    tmo_secs = 16'h0002;
      4'h2:    tmo_secs = 16'h0005;
      4'h3:    tmo_secs = 16'h000A;
      4'h4:    tmo_secs = 16'h001E;
      4'h5:    tmo_secs = 16'h003C;
      4'h6:    tmo_secs = 16'h0078;
      4'h7:    tmo_secs = 16'h012C;
      4'h8:    tmo_secs = 16'h0258;
      default: tmo_secs = 16'h0708;
    endcase
  endfunction

  // ****************************************************************
  // tick and state
  // ****************************************************************
  logic tick;

  sbw_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .ref_clk (ref_clk),
    .rst     (rst),
    .tick    (tick)
  );

  typedef struct packed {
    logic [15:0]          boot_cnt;
    logic                 boot_fired;
    sbw_pkg::sbw_state_t  st;
    logic [15:0]          cnt;
    logic                 sys_reset;
    logic                 pwr_button;
    logic                 overtemp;
    logic                 fatal;
  } sbw_st_t;

  sbw_st_t st_ff;
  sbw_st_t nxt_st;

  logic [1:0]  cur_ev;
  logic [15:0] cur_tmo;
  logic        stage_end;

  always_comb begin
    case (st_ff.st)
      sbw_pkg::SBW_ST1: begin
        cur_ev  = ev1_sel;
        cur_tmo = tmo_secs(tmo1_sel);
      end
      sbw_pkg::SBW_ST2: begin
        cur_ev  = ev2_sel;
        cur_tmo = tmo_secs(tmo2_sel);
      end
      default: begin
        cur_ev  = ev3_sel;
        cur_tmo = tmo_secs(tmo3_sel);
      end
    endcase
  end

  assign stage_end = tick && (st_ff.cnt + 16'h0001 >= cur_tmo);

  always_comb begin
    nxt_st            = st_ff;
    nxt_st.sys_reset  = 1'b0;
    nxt_st.pwr_button = 1'b0;
    nxt_st.overtemp   = 1'b0;
    nxt_st.fatal      = 1'b0;

    // boot-phase timer
    // code 7 decodes to zero seconds: treated as off, like code 0
    if (!post_active || boot_secs(boot_timeout_sel) == 16'h0000) begin
      nxt_st.boot_cnt   = sbw_pkg::CNT_RESET;
      nxt_st.boot_fired = 1'b0;
    end else if (!st_ff.boot_fired && tick && !(boot_pause_en && user_wait)) begin
      if (st_ff.boot_cnt + 16'h0001 >= boot_secs(boot_timeout_sel)) begin
        nxt_st.sys_reset  = 1'b1;
        nxt_st.boot_fired = 1'b1;
      end else begin
        nxt_st.boot_cnt = st_ff.boot_cnt + 16'h0001;
      end
    end

    // runtime watchdog
    case (st_ff.st)
      sbw_pkg::SBW_IDLE: begin
        if (os_arm && rt_mode != sbw_pkg::SBW_MODE_OFF) begin
          nxt_st.cnt = sbw_pkg::CNT_RESET;
          nxt_st.st  = (rt_delay_sel == sbw_pkg::DLY_OFF) ? sbw_pkg::SBW_ST1
                                                          : sbw_pkg::SBW_DELAY;
        end
      end
      sbw_pkg::SBW_DELAY: begin
        if (tick) begin
          if (st_ff.cnt + 16'h0001 >= dly_secs(rt_delay_sel)) begin
            nxt_st.cnt = sbw_pkg::CNT_RESET;
            nxt_st.st  = sbw_pkg::SBW_ST1;
          end else begin
            nxt_st.cnt = st_ff.cnt + 16'h0001;
          end
        end
      end
      sbw_pkg::SBW_ST1, sbw_pkg::SBW_ST2, sbw_pkg::SBW_ST3: begin
        if (sw_trigger) begin
          nxt_st.cnt = sbw_pkg::CNT_RESET;
          nxt_st.st  = (rt_mode == sbw_pkg::SBW_MODE_ONCE) ? sbw_pkg::SBW_DONE
                                                           : sbw_pkg::SBW_ST1;
        end else if (stage_end) begin
          nxt_st.cnt = sbw_pkg::CNT_RESET;
          case (cur_ev)
            sbw_pkg::SBW_EV_ACPI: begin
              nxt_st.overtemp = !acpi_restart_sel;
              nxt_st.fatal    = acpi_restart_sel;
            end
            sbw_pkg::SBW_EV_RESET: nxt_st.sys_reset  = 1'b1;
            sbw_pkg::SBW_EV_PWR:   nxt_st.pwr_button = 1'b1;
            // must not clear a boot reset raised in the same cycle
            default:               nxt_st.fatal      = 1'b0;
          endcase
          // last configured stage: next stage missing or disabled
          if ((st_ff.st == sbw_pkg::SBW_ST1 && ev2_sel != sbw_pkg::SBW_EV_OFF)) begin
            nxt_st.st = sbw_pkg::SBW_ST2;
          end else if (st_ff.st == sbw_pkg::SBW_ST2 && ev3_sel != sbw_pkg::SBW_EV_OFF) begin
            nxt_st.st = sbw_pkg::SBW_ST3;
          end else if (rt_mode == sbw_pkg::SBW_MODE_REPEAT) begin
            nxt_st.st = st_ff.st;
          end else begin
            nxt_st.st = sbw_pkg::SBW_DONE;
          end
        end else if (tick) begin
          nxt_st.cnt = st_ff.cnt + 16'h0001;
        end
      end
      sbw_pkg::SBW_DONE: nxt_st.st = sbw_pkg::SBW_DONE;
      default: nxt_st.st = sbw_pkg::SBW_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sys_reset       = st_ff.sys_reset;
  assign pwr_button      = st_ff.pwr_button;
  assign overtemp_notify = st_ff.overtemp;
  assign acpi_fatal      = st_ff.fatal;
  assign rt_active       = st_ff.st != sbw_pkg::SBW_IDLE && st_ff.st != sbw_pkg::SBW_DONE;
  assign rt_stage        = st_ff.st;

  // ****************************************************************
  // checks
  // ****************************************************************
  a_once_stops: assert property (@(posedge ref_clk) disable iff (rst)
    (rt_active && st_ff.st != sbw_pkg::SBW_DELAY && sw_trigger
     && rt_mode == sbw_pkg::SBW_MODE_ONCE) |=> st_ff.st == sbw_pkg::SBW_DONE)
    else $error("one time trigger did not disable");
  a_trig_restart: assert property (@(posedge ref_clk) disable iff (rst)
    (rt_active && st_ff.st != sbw_pkg::SBW_DELAY && sw_trigger
     && rt_mode != sbw_pkg::SBW_MODE_ONCE) |=> st_ff.st == sbw_pkg::SBW_ST1 && st_ff.cnt == 16'h0)
    else $error("trigger did not restart stage one");
  a_boot_quiet: assert property (@(posedge ref_clk) disable iff (rst)
    (!post_active && st_ff.st == sbw_pkg::SBW_IDLE) |=> !sys_reset)
    else $error("boot reset outside self test");
  a_pause_hold: assert property (@(posedge ref_clk) disable iff (rst)
    (post_active && boot_pause_en && user_wait && $stable(boot_timeout_sel))
    |=> st_ff.boot_cnt == $past(st_ff.boot_cnt) || st_ff.boot_cnt == 16'h0)
    else $error("boot timer ran while paused");
  a_acpi_kind: assert property (@(posedge ref_clk) disable iff (rst)
    !(overtemp_notify && acpi_fatal)) else $error("both acpi actions");
  a_stage_adv: assert property (@(posedge ref_clk) disable iff (rst)
    (st_ff.st == sbw_pkg::SBW_ST1 && stage_end && !sw_trigger
     && ev2_sel != sbw_pkg::SBW_EV_OFF) |=> st_ff.st == sbw_pkg::SBW_ST2)
    else $error("stage two not entered");
  a_single_end: assert property (@(posedge ref_clk) disable iff (rst)
    (st_ff.st == sbw_pkg::SBW_ST3 && stage_end && !sw_trigger
     && rt_mode == sbw_pkg::SBW_MODE_SINGLE) |=> st_ff.st == sbw_pkg::SBW_DONE)
    else $error("single event did not stop");
  a_repeat_hold: assert property (@(posedge ref_clk) disable iff (rst)
    (st_ff.st == sbw_pkg::SBW_ST3 && stage_end && !sw_trigger
     && rt_mode == sbw_pkg::SBW_MODE_REPEAT) |=> st_ff.st == sbw_pkg::SBW_ST3)
    else $error("repeat left last stage");
  a_ev1_fires: assert property (@(posedge ref_clk) disable iff (rst)
    (st_ff.st == sbw_pkg::SBW_ST1 && stage_end && !sw_trigger)
    |=> sys_reset || pwr_button || overtemp_notify || acpi_fatal)
    else $error("stage one event missing");
  c_boot_reset: cover property (@(posedge ref_clk) post_active && sys_reset);
  c_stage3:     cover property (@(posedge ref_clk) st_ff.st == sbw_pkg::SBW_ST3);
  c_once_done:  cover property (@(posedge ref_clk)
    st_ff.st == sbw_pkg::SBW_DONE && rt_mode == sbw_pkg::SBW_MODE_ONCE);
endmodule

// >>> tb/staged_boot_runtime_watchdog_bench.sv
// testbench: staged boot/runtime watchdog against a queue model of its event sequence
module staged_boot_runtime_watchdog_bench;
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************************************
  // signals and state
  // ****************************************************************
  localparam int TK = 10;
  logic                 ref_clk;
  logic                 rst;
  logic [2:0]           boot_timeout_sel;
  logic                 boot_pause_en;
  logic                 post_active;
  logic                 user_wait;
  logic                 os_arm;
  sbw_pkg::sbw_mode_t   rt_mode;
  logic [2:0]           rt_delay_sel;
  sbw_pkg::sbw_event_t  ev1_sel;
  sbw_pkg::sbw_event_t  ev2_sel;
  sbw_pkg::sbw_event_t  ev3_sel;
  logic [3:0]           tmo1_sel;
  logic [3:0]           tmo2_sel;
  logic [3:0]           tmo3_sel;
  logic                 acpi_restart_sel;
  logic                 sw_trigger;
  logic                 sys_reset;
  logic                 pwr_button;
  logic                 overtemp_notify;
  logic                 acpi_fatal;
  logic                 rt_active;
  logic [2:0]           rt_stage;
  int                   miscompares = 0;
  int                   checked = 0;
  int                   seed = 32'h6e70_93e3;
  int                   n;
  int                   r;
  int                   evq[$];
  int                   expq[$];
  int                   boot_s[6] = '{30, 60, 120, 300, 600, 1800};
  int                   tmo_s[10] = '{1, 2, 5, 10, 30, 60, 120, 300, 600, 1800};

  sbw_watchdog #(.TICK_CYCLES(TK)) dut (.ref_clk(ref_clk), .rst(rst),
    .boot_timeout_sel(boot_timeout_sel), .boot_pause_en(boot_pause_en),
    .post_active(post_active), .user_wait(user_wait), .os_arm(os_arm), .rt_mode(rt_mode),
    .rt_delay_sel(rt_delay_sel), .ev1_sel(ev1_sel), .ev2_sel(ev2_sel), .ev3_sel(ev3_sel),
    .tmo1_sel(tmo1_sel), .tmo2_sel(tmo2_sel), .tmo3_sel(tmo3_sel),
    .acpi_restart_sel(acpi_restart_sel), .sw_trigger(sw_trigger), .sys_reset(sys_reset),
    .pwr_button(pwr_button), .overtemp_notify(overtemp_notify), .acpi_fatal(acpi_fatal),
    .rt_active(rt_active), .rt_stage(rt_stage));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic test_done;
    if (miscompares == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // drive and sample 10 ns after the rising edge, where every pulse is settled
  task automatic step;
    @(posedge ref_clk);
    #10;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (exp !== got) begin
      $display("unexpected %s expected %0h seen %0h", what, exp, got);
      miscompares++;
    end
  endtask

  task automatic chk_rng(input string what, input int lo, input int hi, input int got);
    checked++;
    if (got < lo || got > hi) begin
      $display("unexpected %s expected %0d..%0d seen %0d", what, lo, hi, got);
      miscompares++;
    end
  endtask

  task automatic do_reset;
    rst = 1'b1;
    os_arm = 1'b0;
    sw_trigger = 1'b0;
    post_active = 1'b0;
    user_wait = 1'b0;
    boot_pause_en = 1'b0;
    repeat (2) step();
    rst = 1'b0;
  endtask

  task automatic arm;
    os_arm = 1'b1;
    step();
    os_arm = 1'b0;
  endtask

  // stays bounded: a stuck state is a mismatch and ends the run
  task automatic wait_leave(input logic [2:0] st, output int cnt);
    cnt = 0;
    while (rt_stage === st && cnt < 20000) begin
      step();
      cnt++;
    end
    if (cnt >= 20000) begin
      miscompares++;
      test_done();
    end
  endtask

  task automatic wait_boot(input int bound, output int cnt);
    cnt = 0;
    while (sys_reset !== 1'b1 && cnt < bound) begin
      step();
      cnt++;
    end
  endtask

  // acpi shutdown 1, reset 2, power 3, acpi restart 5
  task automatic collect(input int max_ev, input int bound);
    evq.delete();
    for (int i = 0; i < bound && evq.size() < max_ev; i++) begin
      step();
      if (overtemp_notify === 1'b1) evq.push_back(1);
      if (sys_reset === 1'b1) evq.push_back(2);
      if (pwr_button === 1'b1) evq.push_back(3);
      if (acpi_fatal === 1'b1) evq.push_back(5);
    end
  endtask

  function automatic int code(input int ev, input logic rs);
    return (ev == 1) ? (rs ? 5 : 1) : ev;
  endfunction

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    boot_timeout_sel = 3'h0;
    rt_mode = sbw_pkg::SBW_MODE_OFF;
    rt_delay_sel = 3'h0;
    ev1_sel = sbw_pkg::SBW_EV_ACPI;
    ev2_sel = sbw_pkg::SBW_EV_OFF;
    ev3_sel = sbw_pkg::SBW_EV_OFF;
    {tmo1_sel, tmo2_sel, tmo3_sel} = 12'h000;
    acpi_restart_sel = 1'b0;
    do_reset();
    chk("rt_stage", 32'h0, rt_stage);
    step();
    // boot timer on every timeout; user_wait ignored without pause enable
    for (int s = 1; s <= 6; s++) begin
      do_reset();
      boot_timeout_sel = 3'(s);
      post_active = 1'b1;
      user_wait = 1'b1;
      wait_boot(boot_s[s-1] * TK + 20, n);
      chk_rng("boot_cycles", boot_s[s-1] * TK - 11, boot_s[s-1] * TK + 2, n);
    end
    // off codes and a dropped self test never reset
    for (int s = 0; s < 3; s++) begin
      do_reset();
      boot_timeout_sel = (s == 0) ? 3'h0 : (s == 1) ? 3'h7 : 3'h1;
      post_active = (s != 2);
      wait_boot(400, n);
      chk("boot_quiet", 32'd400, n);
    end
    // pause holds the boot count while user interaction is awaited
    do_reset();
    boot_timeout_sel = 3'h1;
    boot_pause_en = 1'b1;
    user_wait = 1'b1;
    post_active = 1'b1;
    wait_boot(500, n);
    chk("boot_paused", 32'd500, n);
    user_wait = 1'b0;
    wait_boot(320, n);
    chk_rng("boot_resume", 289, 302, n);
    // disabled runtime mode ignores arming
    do_reset();
    arm();
    chk("rt_stage", 32'h0, rt_stage);
    step();
    // start delay 10s, then stage one
    rt_mode = sbw_pkg::SBW_MODE_SINGLE;
    rt_delay_sel = 3'h1;
    arm();
    chk("rt_stage", 32'h1, rt_stage);
    wait_leave(3'h1, n);
    chk_rng("delay_cycles", 89, 102, n);
    chk("rt_stage", 32'h3, rt_stage);
    // every stage timeout code
    rt_delay_sel = 3'h0;
    for (int t = 0; t < 10; t++) begin
      do_reset();
      tmo1_sel = 4'(t);
      arm();
      chk("rt_active", 32'h1, rt_active);
      wait_leave(3'h3, n);
      chk_rng("stage_cycles", tmo_s[t] * TK - 11, tmo_s[t] * TK + 2, n);
    end
    tmo1_sel = 4'h0;
    // one time trigger: first trigger disables
    do_reset();
    rt_mode = sbw_pkg::SBW_MODE_ONCE;
    arm();
    sw_trigger = 1'b1;
    step();
    sw_trigger = 1'b0;
    chk("rt_stage", 32'h7, rt_stage);
    collect(1, 100);
    chk("events", 32'h0, evq.size());
    // trigger in stage two returns to stage one
    do_reset();
    rt_mode = sbw_pkg::SBW_MODE_SINGLE;
    ev2_sel = sbw_pkg::SBW_EV_PWR;
    tmo2_sel = 4'h3;
    arm();
    wait_leave(3'h3, n);
    chk("rt_stage", 32'h2, rt_stage);
    repeat (5) step();
    sw_trigger = 1'b1;
    step();
    sw_trigger = 1'b0;
    chk("rt_stage", 32'h3, rt_stage);
    step();
    // random event plans in single and repeated modes against the queue model
    tmo2_sel = 4'h0;
    for (int i = 0; i < 8; i++) begin
      do_reset();
      r = $random(seed);
      rt_mode = i[0] ? sbw_pkg::SBW_MODE_REPEAT : sbw_pkg::SBW_MODE_SINGLE;
      ev1_sel = sbw_pkg::sbw_event_t'(2'(1 + (r[7:0] % 3)));
      // last two plans always reach stage three, once per mode
      ev2_sel = sbw_pkg::sbw_event_t'(r[9:8] | 2'(i / 6));
      ev3_sel = sbw_pkg::sbw_event_t'(r[11:10] | 2'(i / 6));
      acpi_restart_sel = r[12];
      expq.delete();
      expq.push_back(code(int'(ev1_sel), acpi_restart_sel));
      if (ev2_sel != sbw_pkg::SBW_EV_OFF) expq.push_back(code(int'(ev2_sel), acpi_restart_sel));
      if (ev2_sel != sbw_pkg::SBW_EV_OFF && ev3_sel != sbw_pkg::SBW_EV_OFF)
        expq.push_back(code(int'(ev3_sel), acpi_restart_sel));
      while (i[0] && expq.size() < 5) expq.push_back(expq[expq.size()-1]);
      arm();
      collect(5, 150);
      chk("events", expq.size(), evq.size());
      for (int k = 0; k < expq.size() && k < evq.size(); k++)
        chk("event_code", expq[k], evq[k]);
      if (!i[0]) chk("rt_stage", 32'h7, rt_stage);
    end
    test_done();
  end
endmodule
